// ### logic/shared_bus_address_decoder.sv
// Shared bus address decoder, access matrix and module site flag lines.
`timescale 1ns/10ps
`default_nettype none
`include "sbus_regs.svh"
module shared_bus_address_decoder #(parameter int NUM_SITES = 2)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Request from the arbitrated shared bus
    input wire logic reqValid,
    input wire sbus_pkg::master_t reqMaster,
    input wire logic [31:0] reqAddr,
    input wire logic reqWrite,
    // VMEbus window origin update
    input wire logic vmeOriginLoad,
    input wire logic [31:0] vmeOriginValue,
    // Fitted resources, board straps
    input wire logic dramFitted,
    input wire logic [3:0] nodeFitted,
    // Decode answer
    output logic respValid,
    output logic respError,
    output sbus_pkg::target_t respTarget,
    output logic [31:0] respOffset,
    output logic [3:0] respNodeMask,
    output logic respWrite,
    // Module site flag lines
    input wire logic [NUM_SITES*4-1:0] flagPinIn,
    output logic [NUM_SITES*3-1:0] flagPinOut,
    output logic [NUM_SITES*3-1:0] flagPinOe,
    input wire logic [NUM_SITES*3-1:0] flagDrive,
    input wire logic [NUM_SITES*3-1:0] flagDriveEn,
    output logic [NUM_SITES*3-1:0] flagLevel,
    output logic [NUM_SITES-1:0] configLineN
);
    import sbus_pkg::*;

    if (NUM_SITES < 1 || NUM_SITES > 2)
    begin : gSiteCheck
        $error("NUM_SITES must be 1 or 2");
    end

    // ------------------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------------------
    logic [4:0] strapMeta_q;
    logic [4:0] strapSync_q;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            strapMeta_q <= 5'h00;
            strapSync_q <= 5'h00;
        end
        else
        begin
            strapMeta_q <= {dramFitted, nodeFitted};
            strapSync_q <= strapMeta_q;
        end
    end
    wire dramOk = strapSync_q[4];
    wire [3:0] nodesOk = strapSync_q[3:0];

    // ------------------------------------------------------------------------
    // Window origins and longword offset
    // ------------------------------------------------------------------------
    // The VMEbus origin is a plain register so the bridge may relocate it.
    logic [31:0] vmeOrigin_q;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            vmeOrigin_q <= `SB_VME_ORIGIN_RST;
        else if (vmeOriginLoad)
            vmeOrigin_q <= vmeOriginValue;
    end

    wire [5:0] mBits = reqMaster;
    wire isNode = |mBits[3:0];
    wire isExp = mBits[4];
    wire isVme = mBits[5];
    wire [31:0] nodeRel = reqAddr - `SB_NODE_ORIGIN;
    wire [31:0] expRel = reqAddr - `SB_EXP_ORIGIN;
    wire [31:0] vmeRel = reqAddr - vmeOrigin_q;
    wire [31:0] vmeLw = `SB_LW_BASE + {2'b00, vmeRel[31:2]};
    wire nodeIn = reqAddr[31] && (nodeRel >= `SB_LW_BASE);
    wire expIn = expRel >= `SB_LW_BASE;
    wire vmeIn = (vmeRel < `SB_VME_SPAN) && (vmeRel[1:0] == 2'b00);
    wire [31:0] lwOff = isVme ? vmeLw : (isExp ? expRel : nodeRel);
    wire inWin = isVme ? vmeIn : (isExp ? expIn : (isNode && nodeIn));

    // ------------------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------------------
    function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hiExcl);
        inRange = (a >= lo) && (a < hiExcl);
    endfunction : inRange

    wire hitScan = inRange(lwOff, `SB_SCAN_BASE, `SB_BCTL_BASE);
    wire hitBctl = inRange(lwOff, `SB_BCTL_BASE, `SB_BRDG_BASE);
    wire hitBrdg = inRange(lwOff, `SB_BRDG_BASE, `SB_RSV1_BASE);
    wire hitIack = inRange(lwOff, `SB_IACK_BASE, `SB_RSV2_BASE);
    wire hitBirq = inRange(lwOff, `SB_BIRQ_BASE, `SB_ROM_BASE);
    wire hitRom = inRange(lwOff, `SB_ROM_BASE, `SB_RSV3_BASE);
    wire hitXirq = inRange(lwOff, `SB_XIRQ_BASE, `SB_RSV4_BASE);
    wire hitNode = inRange(lwOff, `SB_NODE_BASE, `SB_DRAM_BASE);
    wire hitDram = (lwOff >= `SB_DRAM_BASE) && (lwOff <= `SB_DRAM_END);
    wire hitExpIf = inRange(lwOff, `SB_EXPIF_BASE, `SB_RSV5_BASE);
    wire hitVmem = (lwOff >= `SB_VMEM_BASE) && (lwOff <= `SB_VMEM_END);

    wire [3:0] winMask;
    wire winAllowed;
    node_window_decode uNodeWin
    (
        .winIndex(lwOff[`SB_WIN_MSB:`SB_WIN_LSB]),
        .ownNode(mBits[3:0]),
        .isWrite(reqWrite),
        .nodeFitted(nodesOk),
        .nodeMask(winMask),
        .allowed(winAllowed)
    );

    // ------------------------------------------------------------------------
    // Access matrix and target selection
    // ------------------------------------------------------------------------
    target_t tgt;
    logic permit;
    logic [31:0] regionBase;
    always_comb
    begin
        tgt = TGT_NONE;
        permit = 1'b0;
        regionBase = 32'h0000_0000;
        if (hitScan)
        begin
            tgt = TGT_SCAN;
            permit = isVme;
            regionBase = `SB_SCAN_BASE;
        end
        else if (hitBctl)
        begin
            tgt = TGT_BCTL;
            permit = 1'b1;
            regionBase = `SB_BCTL_BASE;
        end
        else if (hitBrdg)
        begin
            tgt = TGT_BRDG;
            permit = 1'b1;
            regionBase = `SB_BRDG_BASE;
        end
        else if (hitIack)
        begin
            tgt = TGT_IACK;
            permit = !isVme;
            regionBase = `SB_IACK_BASE;
        end
        else if (hitBirq)
        begin
            tgt = TGT_BIRQ;
            permit = 1'b1;
            regionBase = `SB_BIRQ_BASE;
        end
        else if (hitRom)
        begin
            tgt = TGT_ROM;
            permit = 1'b1;
            regionBase = `SB_ROM_BASE;
        end
        else if (hitXirq)
        begin
            tgt = TGT_XIRQ;
            permit = 1'b1;
            regionBase = `SB_XIRQ_BASE;
        end
        else if (hitNode)
        begin
            tgt = TGT_NODE;
            permit = winAllowed;
            regionBase = `SB_NODE_BASE;
        end
        else if (hitDram)
        begin
            tgt = TGT_DRAM;
            permit = dramOk;
            regionBase = `SB_DRAM_BASE;
        end
        else if (hitExpIf)
        begin
            tgt = TGT_EXPIF;
            permit = isNode;
            regionBase = `SB_EXPIF_BASE;
        end
        else if (hitVmem)
        begin
            tgt = TGT_VMEM;
            permit = isNode || isExp;
            regionBase = `SB_VMEM_BASE;
        end
    end

    wire [31:0] baseRel = lwOff - regionBase;
    // Node windows carry the offset unchanged onto the node's own origin.
    wire [31:0] nodeAddr = `SB_NODE_ORIGIN | (lwOff & (`SB_WIN_SIZE - 32'h1));
    // The flash ROM is smaller than its region and mirrors through it.
    wire [31:0] romAddr = lwOff & (`SB_ROM_DEPTH - 32'h1);
    wire accept = inWin && permit && (tgt != TGT_NONE);
    wire [31:0] offNext = (tgt == TGT_NODE) ? nodeAddr :
                          ((tgt == TGT_ROM) ? romAddr : baseRel);

    // ------------------------------------------------------------------------
    // Registered answer
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            respValid <= 1'b0;
            respError <= 1'b0;
            respTarget <= TGT_NONE;
            respOffset <= 32'h0000_0000;
            respNodeMask <= 4'h0;
            respWrite <= 1'b0;
        end
        else
        begin
            respValid <= reqValid;
            respError <= reqValid && !accept;
            respTarget <= (reqValid && accept) ? tgt : TGT_NONE;
            respOffset <= (reqValid && accept) ? offNext : 32'h0000_0000;
            respNodeMask <= (reqValid && accept && tgt == TGT_NODE) ? winMask : 4'h0;
            respWrite <= reqValid && reqWrite;
        end
    end

    // ------------------------------------------------------------------------
    // Module site flag lines
    // ------------------------------------------------------------------------
    // The board only drives a line when its interrupt logic asks; avoiding a
    // second driver on the same line is left to software.
    for (genvar s = 0; s < NUM_SITES; s++)
    begin : gSite
        logic [3:0] pinMeta_q;
        logic [3:0] pinSync_q;
        logic [2:0] drive_q;
        logic [2:0] oe_q;
        always_ff @(posedge clock or negedge resetn)
        begin
            if (!resetn)
            begin
                pinMeta_q <= 4'hF;
                pinSync_q <= 4'hF;
                drive_q <= 3'h0;
                oe_q <= 3'h0;
            end
            else
            begin
                pinMeta_q <= flagPinIn[s*4 +: 4];
                pinSync_q <= pinMeta_q;
                drive_q <= flagDrive[s*3 +: 3];
                oe_q <= flagDriveEn[s*3 +: 3];
            end
        end
        assign flagPinOut[s*3 +: 3] = drive_q;
        assign flagPinOe[s*3 +: 3] = oe_q;
        assign flagLevel[s*3 +: 3] = pinSync_q[2:0];
        assign configLineN[s] = pinSync_q[3];
    end
endmodule : shared_bus_address_decoder
`default_nettype wire

// ### include/sbus_regs.svh
// Address map constants for the shared bus decoder.
`ifndef SBUS_REGS_SVH
`define SBUS_REGS_SVH
// ----------------------------------------------------------------------------
// Window origins
// ----------------------------------------------------------------------------
`define SB_NODE_ORIGIN 32'h8000_0000
`define SB_EXP_ORIGIN 32'h0000_0000
`define SB_VME_ORIGIN_RST 32'h1000_0000
`define SB_VME_SPAN 32'h0800_0000
`define SB_LW_BASE 32'h0800_0000
// ----------------------------------------------------------------------------
// Longword region bases
// ----------------------------------------------------------------------------
`define SB_SCAN_BASE 32'h0800_0000
`define SB_BCTL_BASE 32'h0804_0000
`define SB_BRDG_BASE 32'h0808_0000
`define SB_RSV1_BASE 32'h080C_0000
`define SB_IACK_BASE 32'h0820_0000
`define SB_RSV2_BASE 32'h0830_0000
`define SB_BIRQ_BASE 32'h0840_0000
`define SB_ROM_BASE 32'h0850_0000
`define SB_RSV3_BASE 32'h0860_0000
`define SB_XIRQ_BASE 32'h0870_0000
`define SB_RSV4_BASE 32'h0880_0000
`define SB_NODE_BASE 32'h0888_0000
`define SB_DRAM_BASE 32'h0900_0000
`define SB_DRAM_END 32'h0BFF_FFFF
`define SB_EXPIF_BASE 32'h1000_0000
`define SB_RSV5_BASE 32'h2000_0000
`define SB_VMEM_BASE 32'h4000_0000
`define SB_VMEM_END 32'h7FFF_FFFF
// ----------------------------------------------------------------------------
// Field layouts and sizes
// ----------------------------------------------------------------------------
`define SB_WIN_SIZE 32'h0008_0000
`define SB_WIN_LSB 19
`define SB_WIN_MSB 22
`define SB_ROM_DEPTH 32'h0002_0000
`define SB_FLAG_BIDIR 3
`define SB_FLAG_TOTAL 4
`endif

// ### include/sbus_pkg.sv
// Types shared by the shared bus decoder files.
package sbus_pkg;
    typedef enum logic [5:0]
    {
        MASTER_NODE_A = 6'h01,
        MASTER_NODE_B = 6'h02,
        MASTER_NODE_C = 6'h04,
        MASTER_NODE_D = 6'h08,
        MASTER_EXP = 6'h10,
        MASTER_VME = 6'h20
    } master_t;
    typedef enum logic [11:0]
    {
        TGT_NONE = 12'h001,
        TGT_SCAN = 12'h002,
        TGT_BCTL = 12'h004,
        TGT_BRDG = 12'h008,
        TGT_IACK = 12'h010,
        TGT_BIRQ = 12'h020,
        TGT_ROM = 12'h040,
        TGT_XIRQ = 12'h080,
        TGT_NODE = 12'h100,
        TGT_DRAM = 12'h200,
        TGT_EXPIF = 12'h400,
        TGT_VMEM = 12'h800
    } target_t;
endpackage : sbus_pkg

// ### logic/node_window_decode.sv
// Node global memory window selection and permission check.
`timescale 1ns/10ps
`default_nettype none
module node_window_decode
(
    // Window and requester
    input wire logic [3:0] winIndex,
    input wire logic [3:0] ownNode,
    input wire logic isWrite,
    // Fitted nodes
    input wire logic [3:0] nodeFitted,
    // Result
    output logic [3:0] nodeMask,
    output logic allowed
);
    wire multi;
    wire ownHit;
    wire absent;
    assign nodeMask = winIndex;
    assign multi = |(winIndex & (winIndex - 4'h1));
    assign ownHit = |(winIndex & ownNode);
    assign absent = |(winIndex & ~nodeFitted);
    // Index zero selects no node and is reserved.
    assign allowed = (winIndex != 4'h0) && !ownHit && !absent && (!multi || isWrite);
endmodule : node_window_decode
`default_nettype wire

// ### dv/shared_bus_address_decoder_sva.sv
// Concurrent checks on the shared bus decoder ports.
`timescale 1ns/10ps
`default_nettype none
module shared_bus_address_decoder_sva #(parameter int NUM_SITES = 2)
(
    // Clock, reset and request
    input wire logic clock,
    input wire logic resetn,
    input wire logic reqValid,
    input wire sbus_pkg::master_t reqMaster,
    input wire logic [31:0] reqAddr,
    // Decode answer
    input wire logic respValid,
    input wire logic respError,
    input wire sbus_pkg::target_t respTarget,
    input wire logic [31:0] respOffset,
    input wire logic [3:0] respNodeMask,
    input wire logic respWrite,
    // Flag lines
    input wire logic [NUM_SITES*4-1:0] flagPinIn,
    input wire logic [NUM_SITES*3-1:0] flagLevel,
    input wire logic [NUM_SITES-1:0] configLineN
);
    import sbus_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ------------
    // Properties
    // ------------
    sequence s_req;
        reqValid;
    endsequence
    sequence s_ans;
        respValid && (respError == (respTarget == TGT_NONE));
    endsequence
    property p_answer;
        s_req |=> s_ans;
    endproperty
    property p_idle;
        !reqValid |=> !respValid && respTarget == TGT_NONE;
    endproperty
    property p_scan;
        reqValid && reqMaster != MASTER_VME |=> respTarget != TGT_SCAN;
    endproperty
    property p_vmeDeny;
        reqValid && reqMaster == MASTER_VME |=> !(respTarget inside {TGT_IACK, TGT_VMEM});
    endproperty
    property p_expif;
        reqValid && reqMaster inside {MASTER_EXP, MASTER_VME} |=> respTarget != TGT_EXPIF;
    endproperty
    property p_own;
        s_req |=> (respNodeMask & $past(reqMaster[3:0])) == 4'h0;
    endproperty
    property p_bcast;
        respValid && !$onehot0(respNodeMask) |-> respWrite;
    endproperty
    property p_window;
        respTarget == TGT_NODE |-> respNodeMask != 4'h0 && respOffset[31:19] == 13'h1000;
    endproperty
    property p_nodeOrigin;
        reqValid && reqMaster[3:0] != 4'h0 && !reqAddr[31] |=> respError;
    endproperty
    property p_flags;
        $past(resetn) && $past(resetn, 2) |->
            flagLevel[2:0] == $past(flagPinIn[2:0], 2) && configLineN[0] == $past(flagPinIn[3], 2);
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_scan: assert property (p_scan) else $error("scan set reached by non VME master");
    a_vmeDeny: assert property (p_vmeDeny) else $error("VME reached denied space");
    a_expif: assert property (p_expif) else $error("expansion interface wrongly open");
    a_own: assert property (p_own) else $error("node reached own memory");
    a_bcast: assert property (p_bcast) else $error("multi node read accepted");
    a_window: assert property (p_window) else $error("node window offset wrong");
    a_nodeOrigin: assert property (p_nodeOrigin) else $error("below node origin");
    a_flags: assert property (p_flags) else $error("flag level not tracking pins");
endmodule : shared_bus_address_decoder_sva
`default_nettype wire

// ### dv/site_flag_model.sv
// Module site model that drives the site flag pins.
`timescale 1ns/10ps
`default_nettype none
module site_flag_model #(parameter int NUM_SITES = 2)
(
    // Board side
    input wire logic [NUM_SITES*3-1:0] flagPinOut,
    input wire logic [NUM_SITES*3-1:0] flagPinOe,
    // Processor side
    input wire logic [NUM_SITES*3-1:0] siteDrive,
    input wire logic [NUM_SITES*3-1:0] siteDriveEn,
    input wire logic [NUM_SITES-1:0] siteConfigN,
    // Pins
    output logic [NUM_SITES*4-1:0] flagPinIn
);
    // The lines carry pull-ups, so a released line reads high.
    always_comb
    begin
        for (int s = 0; s < NUM_SITES; s++)
        begin
            for (int k = 0; k < 3; k++)
            begin
                if (flagPinOe[s*3+k])
                    flagPinIn[s*4+k] = flagPinOut[s*3+k];
                else if (siteDriveEn[s*3+k])
                    flagPinIn[s*4+k] = siteDrive[s*3+k];
                else
                    flagPinIn[s*4+k] = 1'b1;
            end
            flagPinIn[s*4+3] = siteConfigN[s];
        end
    end
endmodule : site_flag_model
`default_nettype wire

// ### dv/tb_shared_bus_address_decoder.sv
// Self-checking bench for the shared bus decoder.
`timescale 1ns/10ps
`default_nettype none
module tb_shared_bus_address_decoder;
    import sbus_pkg::*;
    `define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin failures++; \
        $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
    localparam int NUM_SITES = 2;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic reqValid = 1'b0;
    master_t reqMaster = MASTER_NODE_A;
    logic [31:0] reqAddr = 32'h0;
    logic [31:0] vmeOriginValue = 32'h0;
    logic reqWrite = 1'b0;
    logic vmeOriginLoad = 1'b0;
    logic dramFitted = 1'b0;
    logic [3:0] nodeFitted = 4'h0;
    logic respValid, respError, respWrite;
    target_t respTarget;
    logic [31:0] respOffset;
    logic [3:0] respNodeMask;
    logic [7:0] flagPinIn;
    logic [5:0] flagPinOut, flagPinOe, flagLevel;
    logic [5:0] flagDrive = 6'h0, flagDriveEn = 6'h0, siteDrive = 6'h0, siteDriveEn = 6'h0;
    logic [1:0] configLineN;
    logic [1:0] siteConfigN = 2'h3;
    int failures = 0;
    int checksDone = 0;
    // ------------
    // Design and site model
    // ------------
    shared_bus_address_decoder #(.NUM_SITES(NUM_SITES)) dut
    (
        .clock(clock), .resetn(resetn), .reqValid(reqValid), .reqMaster(reqMaster),
        .reqAddr(reqAddr), .reqWrite(reqWrite), .vmeOriginLoad(vmeOriginLoad),
        .vmeOriginValue(vmeOriginValue), .dramFitted(dramFitted), .nodeFitted(nodeFitted),
        .respValid(respValid), .respError(respError), .respTarget(respTarget),
        .respOffset(respOffset), .respNodeMask(respNodeMask), .respWrite(respWrite),
        .flagPinIn(flagPinIn), .flagPinOut(flagPinOut), .flagPinOe(flagPinOe),
        .flagDrive(flagDrive), .flagDriveEn(flagDriveEn), .flagLevel(flagLevel),
        .configLineN(configLineN)
    );
    site_flag_model #(.NUM_SITES(NUM_SITES)) site
    (
        .flagPinOut(flagPinOut), .flagPinOe(flagPinOe), .siteDrive(siteDrive),
        .siteDriveEn(siteDriveEn), .siteConfigN(siteConfigN), .flagPinIn(flagPinIn)
    );
    initial
    begin
        forever #2 clock = ~clock;
    end
    // ------------
    // Tasks
    // ------------
    function automatic logic [31:0] addrOf(input master_t m, input logic [31:0] lw);
        if (m == MASTER_VME)
            return 32'h1000_0000 + ((lw - 32'h0800_0000) << 2);
        return (m == MASTER_EXP) ? lw : 32'h8000_0000 + lw;
    endfunction : addrOf
    task automatic send(input master_t m, input logic [31:0] a, input logic w);
        @(posedge clock);
        #1;
        reqValid = 1'b1;
        reqMaster = m;
        reqAddr = a;
        reqWrite = w;
        @(posedge clock);
        #1;
        reqValid = 1'b0;
    endtask : send
    task automatic probe(input master_t m, input logic [31:0] lw, input logic w,
        input target_t t, input logic [3:0] mk, input logic [31:0] off);
        send(m, addrOf(m, lw), w);
        `CHK("valid", 1'b1, respValid)
        `CHK("target", t, respTarget)
        `CHK("error", t == TGT_NONE, respError)
        `CHK("mask", mk, respNodeMask)
        `CHK("offset", off, respOffset)
        `CHK("write", w, respWrite)
    endtask : probe
    task automatic t_matrix;
        logic [31:0] base [12] = '{32'h0800_0000, 32'h0804_0000, 32'h0808_0000, 32'h0820_0000,
            32'h0840_0000, 32'h0850_0000, 32'h0870_0000, 32'h0900_0000, 32'h1000_0000,
            32'h4000_0000, 32'h080C_0000, 32'h0880_0000};
        target_t tgt [12] = '{TGT_SCAN, TGT_BCTL, TGT_BRDG, TGT_IACK, TGT_BIRQ, TGT_ROM,
            TGT_XIRQ, TGT_DRAM, TGT_EXPIF, TGT_VMEM, TGT_NONE, TGT_NONE};
        logic [5:0] ok [12] = '{6'h20, 6'h3F, 6'h3F, 6'h1F, 6'h3F, 6'h3F, 6'h3F, 6'h3F,
            6'h0F, 6'h1F, 6'h00, 6'h00};
        for (int r = 0; r < 12; r++)
            for (int i = 0; i < 6; i++)
                probe(master_t'(6'h01 << i), base[r], 1'b0, ok[r][i] ? tgt[r] : TGT_NONE,
                    4'h0, 32'h0);
    endtask : t_matrix
    task automatic t_nodes(input logic [3:0] fit);
        logic [3:0] mb;
        logic ok;
        nodeFitted = fit;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 6; i++)
            for (int w = 1; w < 16; w++)
                for (int wr = 0; wr < 2; wr++)
                begin
                    mb = (i < 4) ? 4'(1 << i) : 4'h0;
                    ok = ((w & mb) == 0) && ((w & fit) == w) && (wr == 1 || $countones(w) == 1);
                    probe(master_t'(6'h01 << i), 32'h0880_0004 + w * 32'h0008_0000, wr[0],
                        ok ? TGT_NODE : TGT_NONE, ok ? w[3:0] : 4'h0,
                        ok ? 32'h8000_0004 : 32'h0);
                end
    endtask : t_nodes
    task automatic t_pair;
        @(posedge clock);
        #1;
        reqValid = 1'b1;
        reqMaster = MASTER_NODE_B;
        reqAddr = 32'h8804_0000;
        @(posedge clock);
        #1;
        `CHK("first of pair", TGT_BCTL, respTarget)
        reqAddr = 32'h8820_0000;
        @(posedge clock);
        #1;
        `CHK("acknowledge", TGT_IACK, respTarget)
        reqValid = 1'b0;
    endtask : t_pair
    task automatic t_flags;
        flagDrive = 6'h01;
        flagDriveEn = 6'h01;
        siteDriveEn = 6'h02;
        siteConfigN = 2'h2;
        repeat (4) @(posedge clock);
        #1;
        `CHK("pin enable", 6'h01, flagPinOe)
        `CHK("pin value", 6'h01, flagPinOut)
        `CHK("levels", 6'h3D, flagLevel)
        `CHK("config", 2'h2, configLineN)
        flagDrive = 6'h0;
        flagDriveEn = 6'h0;
        siteDriveEn = 6'h0;
        siteConfigN = 2'h3;
    endtask : t_flags
    task automatic t_origin;
        vmeOriginLoad = 1'b1;
        vmeOriginValue = 32'h2000_0000;
        @(posedge clock);
        #1;
        vmeOriginLoad = 1'b0;
        send(MASTER_VME, 32'h2010_0000, 1'b0);
        `CHK("moved origin", TGT_BCTL, respTarget)
        send(MASTER_VME, 32'h1010_0000, 1'b0);
        `CHK("old origin", TGT_NONE, respTarget)
        send(MASTER_VME, 32'h2010_0002, 1'b0);
        `CHK("unaligned", TGT_NONE, respTarget)
    endtask : t_origin
    // Offsets inside a region, origin edges and an unfitted DRAM strap.
    task automatic t_edges;
        probe(MASTER_NODE_A, 32'h0852_0010, 1'b0, TGT_ROM, 4'h0, 32'h0000_0010);
        probe(MASTER_EXP, 32'h0804_0009, 1'b1, TGT_BCTL, 4'h0, 32'h0000_0009);
        probe(MASTER_NODE_D, 32'h0BFF_FFFF, 1'b0, TGT_DRAM, 4'h0, 32'h02FF_FFFF);
        send(MASTER_NODE_C, 32'h0804_0000, 1'b0);
        `CHK("below node origin", 1'b1, respError)
        send(MASTER_EXP, 32'h0004_0000, 1'b0);
        `CHK("below expansion origin", 1'b1, respError)
        dramFitted = 1'b0;
        repeat (3) @(posedge clock);
        probe(MASTER_NODE_B, 32'h0A00_0000, 1'b1, TGT_NONE, 4'h0, 32'h0);
        dramFitted = 1'b1;
        repeat (3) @(posedge clock);
        probe(MASTER_NODE_B, 32'h0A00_0000, 1'b1, TGT_DRAM, 4'h0, 32'h0100_0000);
    endtask : t_edges
    task automatic summarize;
        if (failures == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        resetn = 1'b1;
        dramFitted = 1'b1;
        nodeFitted = 4'hF;
        repeat (3) @(posedge clock);
        t_matrix;
        t_nodes(4'hF);
        t_nodes(4'h7);
        t_pair;
        t_flags;
        t_origin;
        t_edges;
        summarize;
    end
    // The whole run needs some 920 cycles, so this leaves ample margin.
    initial
    begin
        #50000;
        failures++;
        summarize;
    end
endmodule : tb_shared_bus_address_decoder
bind shared_bus_address_decoder shared_bus_address_decoder_sva #(.NUM_SITES(NUM_SITES)) chk
(
    .clock(clock), .resetn(resetn), .reqValid(reqValid), .reqMaster(reqMaster),
    .reqAddr(reqAddr), .respValid(respValid), .respError(respError),
    .respTarget(respTarget), .respOffset(respOffset), .respNodeMask(respNodeMask),
    .respWrite(respWrite), .flagPinIn(flagPinIn), .flagLevel(flagLevel),
    .configLineN(configLineN)
);
`default_nettype wire
